// ### sim/sat_exec_props.sv
// port-level assertions for the skip/transfer unit
module sat_exec_props (
   input wire logic        clock,
   input wire logic        rst,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [7:0]  first_timer_count,
   input wire logic [7:0]  first_timer_reload,
   input wire logic        first_timer_load,
   input wire logic [7:0]  second_timer_count,
   input wire logic [7:0]  second_timer_reload,
   input wire logic        second_timer_load,
   input wire logic        rom_rd
);
   // one clock domain, so clocking and disable are shared
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("write answer dropped early");
   bvalid_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer repeated");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("read answer changed early");
   wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answer pending");
   rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   t1_pulse_a: assert property (first_timer_load |=> !first_timer_load)
      else $error("timer1 load longer than one cycle");
   t1_pair_a: assert property (first_timer_load |->
      first_timer_count == first_timer_reload)
      else $error("timer1 count and reload differ");
   t2_pulse_a: assert property (second_timer_load |=> !second_timer_load)
      else $error("timer2 load longer than one cycle");
   t2_pair_a: assert property (second_timer_load |->
      second_timer_count == second_timer_reload)
      else $error("timer2 count and reload differ");
   rom_pulse_a: assert property (rom_rd |=> !rom_rd)
      else $error("rom read longer than one cycle");
endmodule
bind sat_exec sat_exec_props u_props (.*);

// ### sim/sat_exec_tb.sv
// self-checking bench for the skip/transfer unit over its register bus
module sat_exec_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 0, rst = 1, ext_pin = 0, powerdown_flag = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0;
   logic first_timer_event = 0, second_timer_event = 0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
   logic [3:0] s_axi_wstrb = 4'hF, ram_nibble = 4'h0, portd_in = 4'h0;
   logic [7:0] first_timer_value = 8'h00, second_timer_value = 8'h00;
   logic [9:0] converter_result = 10'h000, rom_data = 10'h000;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [7:0] first_timer_count, first_timer_reload, second_timer_count, second_timer_reload;
   logic first_timer_load, second_timer_load, rom_rd;
   logic [11:0] rom_addr, seen_addr = 12'h000;
   int n_fail = 0, num_checks = 0;
   // clock of 25 ns
   always #12.5 clock = ~clock;
   sat_exec dut (.*);
   // rom address is loaded together with its strobe, so catch it there
   always @(posedge clock) begin
      if (rom_rd === 1'b1) begin
         seen_addr <= rom_addr;
      end
   end
   task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   // readies are looked at before the edge that takes the item
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ta = 0, tw = 0, tb = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int n = 0; n < 50 && !tb; n++) begin
         @(negedge clock);
         ta = ta | (s_axi_awready === 1'b1);
         tw = tw | (s_axi_wready === 1'b1);
         tb = s_axi_bvalid === 1'b1;
         if (tb) rsp = s_axi_bresp;
         @(posedge clock);
         if (ta && s_axi_awvalid) s_axi_awvalid <= 1'b0;
         if (tw && s_axi_wvalid) s_axi_wvalid <= 1'b0;
      end
   endtask
   task automatic rd(input logic [7:0] a);
      logic ta = 0, tr = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int n = 0; n < 50 && !tr; n++) begin
         @(negedge clock);
         ta = ta | (s_axi_arready === 1'b1);
         tr = s_axi_rvalid === 1'b1;
         rv = s_axi_rdata;
         rsp = s_axi_rresp;
         @(posedge clock);
         if (ta && s_axi_arvalid) s_axi_arvalid <= 1'b0;
      end
   endtask
   // issue one instruction, then poll busy
   task automatic exec(input logic [4:0] op, input logic [4:0] imm);
      wr(8'h00, {19'h0, imm, 3'h0, op});
      rv = 32'h1;
      for (int n = 0; n < 20 && rv[0] !== 1'b0; n++) rd(8'h04);
   endtask
   task automatic t_load;
      wr(8'h08, 32'h0A5);
      exec(5'h08, 5'h00);
      chk("t1 count", first_timer_count, 8'hA5);
      chk("t1 reload", first_timer_reload, 8'hA5);
      wr(8'h08, 32'h05A);
      exec(5'h09, 5'h00);
      chk("t2 count", second_timer_count, 8'h5A);
      chk("t2 reload", second_timer_reload, 8'h5A);
      first_timer_value <= 8'h3C;
      exec(5'h0B, 5'h00);
      rd(8'h08);
      chk("t1 read", rv[7:0], 8'h3C);
      $display("t_load done");
   endtask
   task automatic t_ad;
      converter_result <= 10'h2D6;
      for (int m = 0; m < 2; m++) begin
         wr(8'h0C, 32'(m) << 3);
         exec(5'h0D, 5'h00);
         rd(8'h08);
         chk("ad read", rv[7:0], (m == 1) ? 8'hD6 : 8'hB5);
      end
      $display("t_ad done");
   endtask
   // taken skip must swallow the next copy of b into a
   task automatic t_skip;
      wr(8'h0C, 32'h1);
      ext_pin <= 1'b1;
      powerdown_flag <= 1'b1;
      for (int k = 1; k < 3; k++) begin
         wr(8'h08, 32'h1A3);
         exec(5'(k), 5'h00);
         rd(8'h04);
         chk("skip pending", rv[1], 1'b1);
         exec(5'h0A, 5'h00);
         rd(8'h08);
         chk("skipped acc", rv[8:0], 9'h1A3);
      end
      exec(5'h0A, 5'h00);
      rd(8'h08);
      chk("b to a", rv[8:0], 9'h1AA);
      ext_pin <= 1'b0;
      exec(5'h01, 5'h00);
      chk("no skip", rv[1], 1'b0);
      $display("t_skip done");
   endtask
   task automatic t_table;
      wr(8'h0C, 32'h30);
      wr(8'h08, 32'h4);
      rom_data <= 10'h3C7;
      exec(5'h0F, 5'h05);
      chk("table addr", seen_addr, {5'h05, 3'h3, 4'h4});
      rd(8'h08);
      chk("table data", rv[7:0], 8'hC7);
      rd(8'h40);
      chk("unmapped", rsp, 2'h2);
      $display("t_table done");
   endtask
   // remaining skips except the timer 2 one, each consumed by a skipped nop
   task automatic t_more;
      first_timer_event <= 1'b1;
      wr(8'h10, 32'h9F);
      first_timer_event <= 1'b0;
      ram_nibble <= 4'hB;
      portd_in <= 4'hB;
      second_timer_value <= 8'hE1;
      wr(8'h0C, 32'h270);
      for (int k = 0; k < 4; k++) begin
         exec(5'(k == 0 ? 3 : k + 4), 5'h02);
         chk("skip taken", rv[2:1], 2'h1);
         exec(5'h00, 5'h00);
      end
      wr(8'h0C, 32'h470);
      exec(5'h07, 5'h00);
      chk("y above 3", rv[1], 1'b0);
      exec(5'h0E, 5'h00);
      exec(5'h10, 5'h00);
      rd(8'h08);
      chk("split and page", rv[7:0], 8'h97);
      exec(5'h0C, 5'h00);
      rd(8'h08);
      chk("t2 read", rv[7:0], 8'hE1);
      wr(8'h44, 32'h0);
      chk("bad write", rsp, 2'h2);
      $display("t_more done");
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // main sequence after ten cycles of reset
   initial begin
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      t_load;
      t_ad;
      t_skip;
      t_table;
      t_more;
      close_out;
   end
   // watchdog far beyond the few hundred cycles the tests need
   initial begin
      #500000;
      n_fail++;
      close_out;
   end
endmodule

// ### src/sat_cond.sv
// skip condition judge: decides skip and flag clears for the current op
`include "sat_defs.svh"
module sat_cond (
   sat_cond_if.judge cif
);
   // pure decode; the sequencer gates the answers with its own timing
   always_comb begin
      cif.skip   = 1'b0;
      cif.clr_t1 = 1'b0;
      cif.clr_t2 = 1'b0;
      case (cif.op)
         sat_pkg::SAT_OP_SKIP_EXT: begin
            cif.skip = (cif.ext_pin == cif.ext_pol);
         end
         sat_pkg::SAT_OP_SKIP_PD: begin
            cif.skip = cif.pd_flag;
         end
         sat_pkg::SAT_OP_SKIP_T1: begin
            if (!cif.t1_irq_en) begin
               cif.skip   = cif.t1_flag;
               cif.clr_t1 = cif.t1_flag;
            end
         end
         sat_pkg::SAT_OP_SKIP_T2: begin
            if (!cif.t2_irq_en) begin
               cif.skip   = cif.t2_flag;
               cif.clr_t2 = cif.t2_flag;
            end
         end
         sat_pkg::SAT_OP_SKIP_MEMBIT: begin
            cif.skip = ~cif.mem_nibble[cif.bit_sel];
         end
         sat_pkg::SAT_OP_SKIP_CY: begin
            cif.skip = ~cif.carry;
         end
         sat_pkg::SAT_OP_SKIP_PORTD: begin
            // decided in the second word; y above 3 never skips
            if (cif.second_word && (cif.y_reg <= `SAT_PORTD_TOP)) begin
               cif.skip = ~cif.portd[cif.y_reg[1:0]];
            end
         end
         default: begin
            cif.skip = 1'b0;
         end
      endcase
   end
endmodule

// ### src/sat_cond_if.sv
// carrier between the sequencer and the skip condition judge
interface sat_cond_if;
   sat_pkg::sat_op_t op;
   logic [1:0]       bit_sel;
   logic             second_word;
   logic             ext_pin;
   logic             ext_pol;
   logic             pd_flag;
   logic             t1_flag;
   logic             t1_irq_en;
   logic             t2_flag;
   logic             t2_irq_en;
   logic [3:0]       mem_nibble;
   logic             carry;
   logic [3:0]       portd;
   logic [3:0]       y_reg;
   logic             skip;
   logic             clr_t1;
   logic             clr_t2;

   modport judge (
      input  op, bit_sel, second_word, ext_pin, ext_pol, pd_flag, t1_flag, t1_irq_en,
      input  t2_flag, t2_irq_en, mem_nibble, carry, portd, y_reg,
      output skip, clr_t1, clr_t2
   );
   modport core (
      output op, bit_sel, second_word, ext_pin, ext_pol, pd_flag, t1_flag, t1_irq_en,
      output t2_flag, t2_irq_en, mem_nibble, carry, portd, y_reg,
      input  skip, clr_t1, clr_t2
   );
endinterface

// ### src/sat_defs.svh
// offsets, field positions, reset values and bus answers of the skip/transfer unit
`ifndef SAT_DEFS_SVH
`define SAT_DEFS_SVH
`define SAT_ADDR_W      8
`define SAT_OFF_CTRL    8'h00
`define SAT_OFF_STATUS  8'h04
`define SAT_OFF_ACC     8'h08
`define SAT_OFF_CFG     8'h0C
`define SAT_OFF_EREG    8'h10
`define SAT_OFF_TIMER   8'h14
`define SAT_OFF_PC      8'h18
`define SAT_CTRL_OP_LSB   0
`define SAT_CTRL_IMM_LSB  8
`define SAT_ACC_A_LSB     0
`define SAT_ACC_B_LSB     4
`define SAT_ACC_CY_BIT    8
`define SAT_CFG_POL_BIT   0
`define SAT_CFG_V12_BIT   1
`define SAT_CFG_V13_BIT   2
`define SAT_CFG_Q13_BIT   3
`define SAT_CFG_DR_LSB    4
`define SAT_CFG_Y_LSB     8
`define SAT_PORTD_TOP     4'h3
`define SAT_RST_NIB       4'h0
`define SAT_RST_BYTE      8'h00
`define SAT_RST_PC        12'h000
`define SAT_RESP_OKAY     2'h0
`define SAT_RESP_SLVERR   2'h2
`endif

// ### src/sat_exec.sv
// skip and transfer execution unit with its axi4-lite register slave
//
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`include "sat_defs.svh"
module sat_exec (
   input  wire logic                   clock,
   input  wire logic                   rst,
   input  wire logic [`SAT_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [`SAT_ADDR_W-1:0] s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   input  wire logic                   ext_pin,
   input  wire logic                   powerdown_flag,
   input  wire logic                   first_timer_event,
   input  wire logic                   second_timer_event,
   input  wire logic [3:0]             ram_nibble,
   input  wire logic [3:0]             portd_in,
   input  wire logic [7:0]             first_timer_value,
   input  wire logic [7:0]             second_timer_value,
   input  wire logic [9:0]             converter_result,
   input  wire logic [9:0]             rom_data,
   output logic [7:0]                  first_timer_count,
   output logic [7:0]                  first_timer_reload,
   output logic                        first_timer_load,
   output logic [7:0]                  second_timer_count,
   output logic [7:0]                  second_timer_reload,
   output logic                        second_timer_load,
   output logic [11:0]                 rom_addr,
   output logic                        rom_rd
);
   sat_cond_if cif ();

   sat_pkg::sat_state_t   state;
   sat_pkg::sat_op_t      cur_op;
   logic [4:0]            cur_imm;
   logic                  suppress;
   logic                  skip_pending;
   logic [3:0]            acc;
   logic [3:0]            breg;
   logic                  carry_flag;
   logic                  ext_pin_polarity_bit;
   logic                  first_timer_irq_enable_bit;
   logic                  second_timer_irq_enable_bit;
   logic                  converter_compare_mode_bit;
   logic [2:0]            page_register;
   logic [3:0]            y_reg;
   logic [7:0]            e_reg;
   logic                  first_timer_request_flag;
   logic                  second_timer_request_flag;
   logic [11:0]           pc;
   logic [11:0]           stack_pc;
   logic                  aw_hold;
   logic                  w_hold;
   logic [`SAT_ADDR_W-1:0] aw_addr;
   logic [31:0]           w_data;
   logic [3:0]            w_strb;
   logic [31:0]           wr_mask;
   logic [31:0]           wr_old;
   logic [31:0]           wr_val;
   logic                  wr_fire;
   logic                  wr_hit;
   logic [31:0]           rd_val;
   logic                  rd_hit;
   logic                  go;
   logic                  exec_fx;
   logic                  sec_fx;
   logic                  third_fx;
   logic                  is_table;
   logic [11:0]           table_addr;

   // byte lanes expand to a bit mask, one lane per loop pass
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
         assign wr_mask[8*gi +: 8] = {8{w_strb[gi]}};
      end
   endgenerate

   // write side accepts address and data in either order
   assign s_axi_awready = ~aw_hold & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_hold & ~s_axi_bvalid;
   assign wr_fire       = aw_hold & w_hold & ~s_axi_bvalid;
   assign wr_val        = (wr_old & ~wr_mask) | (w_data & wr_mask);
   assign s_axi_arready = ~s_axi_rvalid;

   // register image, used for reads and for merging partial writes
   function automatic logic [31:0] reg_image(input logic [`SAT_ADDR_W-1:0] a);
      logic [31:0] v;
      v = 32'h0000_0000;
      case (a)
         `SAT_OFF_CTRL:   v[12:0] = {cur_imm, 3'h0, cur_op};
         `SAT_OFF_STATUS: v[4:0]  = {suppress, second_timer_request_flag,
                                     first_timer_request_flag, skip_pending,
                                     state != sat_pkg::SAT_ST_IDLE};
         `SAT_OFF_ACC:    v[8:0]  = {carry_flag, breg, acc};
         `SAT_OFF_CFG:    v[11:0] = {y_reg, 1'b0, page_register, converter_compare_mode_bit,
                                     second_timer_irq_enable_bit,
                                     first_timer_irq_enable_bit, ext_pin_polarity_bit};
         `SAT_OFF_EREG:   v[7:0]  = e_reg;
         `SAT_OFF_TIMER:  v = {second_timer_reload, second_timer_count,
                               first_timer_reload, first_timer_count};
         `SAT_OFF_PC:     v[11:0] = pc;
         default:         v = 32'h0000_0000;
      endcase
      return v;
   endfunction

   function automatic logic mapped(input logic [`SAT_ADDR_W-1:0] a);
      return (a == `SAT_OFF_CTRL) || (a == `SAT_OFF_STATUS) || (a == `SAT_OFF_ACC) ||
             (a == `SAT_OFF_CFG) || (a == `SAT_OFF_EREG) || (a == `SAT_OFF_TIMER) ||
             (a == `SAT_OFF_PC);
   endfunction

   always_comb begin
      wr_old = reg_image(aw_addr);
      wr_hit = mapped(aw_addr);
      rd_val = reg_image(s_axi_araddr);
      rd_hit = mapped(s_axi_araddr);
   end

   // write channel capture and response
   always_ff @(posedge clock) begin
      if (rst) begin
         aw_hold      <= 1'b0;
         w_hold       <= 1'b0;
         aw_addr      <= '0;
         w_data       <= 32'h0000_0000;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `SAT_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_hold      <= 1'b0;
            w_hold       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `SAT_RESP_OKAY : `SAT_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // read channel, answer one cycle after the address is taken
   always_ff @(posedge clock) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `SAT_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_val;
         s_axi_rresp  <= rd_hit ? `SAT_RESP_OKAY : `SAT_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // a ctrl write while busy is dropped; software polls the busy bit first
   assign go       = wr_fire && (aw_addr == `SAT_OFF_CTRL) &&
                     (state == sat_pkg::SAT_ST_IDLE);
   assign exec_fx  = (state == sat_pkg::SAT_ST_EXEC) && !suppress;
   assign sec_fx   = (state == sat_pkg::SAT_ST_SECOND) && !suppress;
   assign third_fx = (state == sat_pkg::SAT_ST_THIRD) && !suppress;
   assign is_table = (cur_op == sat_pkg::SAT_OP_TABLE);
   assign table_addr = {cur_imm, page_register, acc};

   // operation latch; suppress remembers that this instruction is the skipped one
   always_ff @(posedge clock) begin
      if (rst) begin
         cur_op   <= sat_pkg::SAT_OP_NOP;
         cur_imm  <= 5'h00;
         suppress <= 1'b0;
      end else if (go) begin
         cur_op   <= sat_pkg::sat_op_t'(wr_val[`SAT_CTRL_OP_LSB +: 5]);
         cur_imm  <= wr_val[`SAT_CTRL_IMM_LSB +: 5];
         suppress <= skip_pending;
      end
   end

   // sequencer: a skipped portd test still takes its second slot, a skipped table read only its first; neither does anything
   always_ff @(posedge clock) begin
      if (rst) begin
         state <= sat_pkg::SAT_ST_IDLE;
      end else begin
         case (state)
            sat_pkg::SAT_ST_IDLE: begin
               if (go) state <= sat_pkg::SAT_ST_EXEC;
            end
            sat_pkg::SAT_ST_EXEC: begin
               if ((cur_op == sat_pkg::SAT_OP_SKIP_PORTD) || (is_table && !suppress))
                  state <= sat_pkg::SAT_ST_SECOND;
               else
                  state <= sat_pkg::SAT_ST_IDLE;
            end
            sat_pkg::SAT_ST_SECOND: begin
               if (is_table && !suppress)
                  state <= sat_pkg::SAT_ST_THIRD;
               else
                  state <= sat_pkg::SAT_ST_IDLE;
            end
            sat_pkg::SAT_ST_THIRD: begin
               state <= sat_pkg::SAT_ST_IDLE;
            end
            default: begin
               state <= sat_pkg::SAT_ST_IDLE;
            end
         endcase
      end
   end

   // hook the condition judge to live state
   assign cif.op          = cur_op;
   assign cif.bit_sel     = cur_imm[1:0];
   assign cif.second_word = (state == sat_pkg::SAT_ST_SECOND);
   assign cif.ext_pin     = ext_pin;
   assign cif.ext_pol     = ext_pin_polarity_bit;
   assign cif.pd_flag     = powerdown_flag;
   assign cif.t1_flag     = first_timer_request_flag;
   assign cif.t1_irq_en   = first_timer_irq_enable_bit;
   assign cif.t2_flag     = second_timer_request_flag;
   assign cif.t2_irq_en   = second_timer_irq_enable_bit;
   assign cif.mem_nibble  = ram_nibble;
   assign cif.carry       = carry_flag;
   assign cif.portd       = portd_in;
   assign cif.y_reg       = y_reg;

   sat_cond u_cond (
      .cif (cif)
   );

   // pending skip arms on a taken test, consumed by the next instruction
   always_ff @(posedge clock) begin
      if (rst) begin
         skip_pending <= 1'b0;
      end else if (go) begin
         skip_pending <= 1'b0;
      end else if ((exec_fx || sec_fx) && cif.skip) begin
         skip_pending <= 1'b1;
      end
   end

   // timer request flags: a timer event in the clear cycle wins
   always_ff @(posedge clock) begin
      if (rst) begin
         first_timer_request_flag  <= 1'b0;
         second_timer_request_flag <= 1'b0;
      end else begin
         if (first_timer_event)
            first_timer_request_flag <= 1'b1;
         else if (exec_fx && cif.clr_t1)
            first_timer_request_flag <= 1'b0;
         if (second_timer_event)
            second_timer_request_flag <= 1'b1;
         else if (exec_fx && cif.clr_t2)
            second_timer_request_flag <= 1'b0;
      end
   end

   // accumulator and b: instruction results beat software writes
   always_ff @(posedge clock) begin
      if (rst) begin
         acc  <= `SAT_RST_NIB;
         breg <= `SAT_RST_NIB;
      end else if (exec_fx) begin
         case (cur_op)
            sat_pkg::SAT_OP_B_TO_ACC: acc <= breg;
            sat_pkg::SAT_OP_READ_T1: begin
               breg <= first_timer_value[7:4];
               acc  <= first_timer_value[3:0];
            end
            sat_pkg::SAT_OP_READ_T2: begin
               breg <= second_timer_value[7:4];
               acc  <= second_timer_value[3:0];
            end
            sat_pkg::SAT_OP_READ_AD: begin
               if (converter_compare_mode_bit) begin
                  breg <= converter_result[7:4];
                  acc  <= converter_result[3:0];
               end else begin
                  breg <= converter_result[9:6];
                  acc  <= converter_result[5:2];
               end
            end
            sat_pkg::SAT_OP_SPLIT_E: begin
               breg <= e_reg[7:4];
               acc  <= e_reg[3:0];
            end
            sat_pkg::SAT_OP_READ_PAGE: acc <= {1'b0, page_register};
            default: begin
               acc <= acc;
            end
         endcase
      end else if (sec_fx && is_table) begin
         breg <= rom_data[7:4];
         acc  <= rom_data[3:0];
      end else if (wr_fire && (aw_addr == `SAT_OFF_ACC)) begin
         acc  <= wr_val[`SAT_ACC_A_LSB +: 4];
         breg <= wr_val[`SAT_ACC_B_LSB +: 4];
      end
   end

   // carry and configuration bits are software owned; no op here alters carry
   always_ff @(posedge clock) begin
      if (rst) begin
         carry_flag                  <= 1'b0;
         ext_pin_polarity_bit        <= 1'b0;
         first_timer_irq_enable_bit  <= 1'b0;
         second_timer_irq_enable_bit <= 1'b0;
         converter_compare_mode_bit  <= 1'b0;
         page_register               <= 3'h0;
         y_reg                       <= `SAT_RST_NIB;
         e_reg                       <= `SAT_RST_BYTE;
      end else if (wr_fire) begin
         if (aw_addr == `SAT_OFF_ACC)
            carry_flag <= wr_val[`SAT_ACC_CY_BIT];
         if (aw_addr == `SAT_OFF_CFG) begin
            ext_pin_polarity_bit        <= wr_val[`SAT_CFG_POL_BIT];
            first_timer_irq_enable_bit  <= wr_val[`SAT_CFG_V12_BIT];
            second_timer_irq_enable_bit <= wr_val[`SAT_CFG_V13_BIT];
            converter_compare_mode_bit  <= wr_val[`SAT_CFG_Q13_BIT];
            page_register               <= wr_val[`SAT_CFG_DR_LSB +: 3];
            y_reg                       <= wr_val[`SAT_CFG_Y_LSB +: 4];
         end
         if (aw_addr == `SAT_OFF_EREG)
            e_reg <= wr_val[7:0];
      end
   end

   // timer count and reload written together, load strobe to the timer unit
   always_ff @(posedge clock) begin
      if (rst) begin
         first_timer_count   <= `SAT_RST_BYTE;
         first_timer_reload  <= `SAT_RST_BYTE;
         second_timer_count  <= `SAT_RST_BYTE;
         second_timer_reload <= `SAT_RST_BYTE;
         first_timer_load    <= 1'b0;
         second_timer_load   <= 1'b0;
      end else begin
         first_timer_load  <= exec_fx && (cur_op == sat_pkg::SAT_OP_LOAD_T1);
         second_timer_load <= exec_fx && (cur_op == sat_pkg::SAT_OP_LOAD_T2);
         if (exec_fx && (cur_op == sat_pkg::SAT_OP_LOAD_T1)) begin
            first_timer_count  <= {breg, acc};
            first_timer_reload <= {breg, acc};
         end
         if (exec_fx && (cur_op == sat_pkg::SAT_OP_LOAD_T2)) begin
            second_timer_count  <= {breg, acc};
            second_timer_reload <= {breg, acc};
         end
      end
   end

   // table read: one-deep save of pc, rom fetch, restore in the third cycle
   always_ff @(posedge clock) begin
      if (rst) begin
         pc       <= `SAT_RST_PC;
         stack_pc <= `SAT_RST_PC;
         rom_addr <= `SAT_RST_PC;
         rom_rd   <= 1'b0;
      end else begin
         rom_rd <= exec_fx && is_table;
         if (exec_fx && is_table) begin
            stack_pc <= pc;
            pc       <= table_addr;
            rom_addr <= table_addr;
         end else if (third_fx && is_table) begin
            pc <= stack_pc;
         end else if (wr_fire && (aw_addr == `SAT_OFF_PC)) begin
            pc <= wr_val[11:0];
         end
      end
   end
endmodule

// ### src/sat_pkg.sv
// types of the skip/transfer unit: operation codes and sequencer states
package sat_pkg;
   typedef enum logic [4:0] {
      SAT_OP_NOP         = 5'h00,
      SAT_OP_SKIP_EXT    = 5'h01,
      SAT_OP_SKIP_PD     = 5'h02,
      SAT_OP_SKIP_T1     = 5'h03,
      SAT_OP_SKIP_T2     = 5'h04,
      SAT_OP_SKIP_MEMBIT = 5'h05,
      SAT_OP_SKIP_CY     = 5'h06,
      SAT_OP_SKIP_PORTD  = 5'h07,
      SAT_OP_LOAD_T1     = 5'h08,
      SAT_OP_LOAD_T2     = 5'h09,
      SAT_OP_B_TO_ACC    = 5'h0A,
      SAT_OP_READ_T1     = 5'h0B,
      SAT_OP_READ_T2     = 5'h0C,
      SAT_OP_READ_AD     = 5'h0D,
      SAT_OP_SPLIT_E     = 5'h0E,
      SAT_OP_TABLE       = 5'h0F,
      SAT_OP_READ_PAGE   = 5'h10
   } sat_op_t;

   typedef enum logic [3:0] {
      SAT_ST_IDLE   = 4'h1,
      SAT_ST_EXEC   = 4'h2,
      SAT_ST_SECOND = 4'h4,
      SAT_ST_THIRD  = 4'h8
   } sat_state_t;
endpackage
